// File: rtl/sar_pkg.sv
// Purpose: Constants and types for the spectral alarm reporting block.
// Assumes: 16-bit register words, byte addresses on a 7-bit register port.
// Notes:   Offsets other than the global command word are local choices.
package sar_pkg;
   localparam int          NUM_BANDS     = 6;
   localparam int          NUM_RATES     = 4;
   localparam int          NUM_AXES      = 3;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [6:0]  OFS_GLOBAL_COMMAND  = 7'h3E;
   localparam logic [6:0]  OFS_BAND_PTR  = 7'h40;
   localparam logic [6:0]  OFS_BAND_LOW  = 7'h42;
   localparam logic [6:0]  OFS_BAND_HIGH = 7'h44;
   localparam logic [6:0]  OFS_TRIG1     = 7'h46; // x, y, z at +0, +2, +4
   localparam logic [6:0]  OFS_TRIG2     = 7'h4C;
   localparam logic [6:0]  OFS_ALARM_CONTROL  = 7'h52;
   localparam logic [6:0]  OFS_AUX_CTRL  = 7'h54;
   localparam logic [6:0]  OFS_STAT      = 7'h56;
   localparam logic [6:0]  OFS_PEAK      = 7'h5C;
   localparam logic [6:0]  OFS_BIN       = 7'h62;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          CMD_CLEAR_BIT = 9;
   localparam int          CMD_SAVE_BIT  = 12;
   localparam int          ACTL_PIN_BIT  = 6;
   localparam int          ACTL_DLY_LSB  = 8;
   localparam int          AUXC_SEL_LSB  = 2;
   localparam logic [3:0]  AUX_SEL_ALARM = 4'h4;
   localparam logic [15:0] ACTL_RST      = 16'h0080;
   localparam logic [15:0] AUXC_RST      = 16'h0000;
   localparam logic [15:0] STAT_RST      = 16'h0000;

   typedef struct packed {
      logic [1:0]  axis;
      logic [7:0]  idx;
      logic [15:0] mag;
   } sar_bin_t;

   typedef struct packed {
      logic [15:0] stat;
      logic [15:0] peak;
      logic [15:0] bin;
   } sar_axis_hdr_t;

   typedef struct packed {
      logic [5:0]                diag;
      sar_axis_hdr_t [2:0]       ax;
   } sar_hdr_t;

   typedef enum logic [0:0] {
      SAR_IDLE  = 1'b0,
      SAR_ACCUM = 1'b1
   } sar_st_t;
endpackage

// File: rtl/sar_core.sv
// Purpose: Spectral band alarm evaluation, reporting and alarm pin drive.
// Assumes: Bins, record strobes and register port come from logic on clk_sys_i.
// Notes:   Register reads answer one enabled cycle after the read strobe.
`timescale 1ns/100ps
module sar_core (
   input  wire logic            clk_sys_i,
   input  wire logic            rst_b_i,
   input  wire logic            clk_en_i,
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   input  wire logic [6:0]      reg_addr_i,
   input  wire logic [15:0]     reg_wdata_i,
   output logic      [15:0]     reg_rdata_o,
   input  wire logic [1:0]      rate_sel_i,
   input  wire logic [5:0]      diag_flags_i,
   input  wire logic            rec_start_i,
   input  wire logic            rec_end_i,
   input  wire logic            bin_valid_i,
   input  wire sar_pkg::sar_bin_t bin_i,
   output sar_pkg::sar_hdr_t    hdr_o,
   output logic                 hdr_valid_o,
   output logic                 aux_pin_one_o,
   output logic                 aux_pin_one_oe_b_o,
   output logic                 aux_pin_two_o,
   output logic                 aux_pin_two_oe_b_o
);
   import sar_pkg::*;

   typedef logic [NUM_RATES-1:0][NUM_BANDS-1:0][1:0][7:0] sar_bands_t;

   function automatic logic in_band(input logic [7:0] b, input logic [1:0][7:0] lh);
      in_band = (b >= lh[0]) && (b <= lh[1]);
   endfunction

   // ---------------------------------------------------------------
   // Configuration state
   // ---------------------------------------------------------------
   sar_bands_t                  stage_q, stage_d, active_q, active_d;
   logic                        committed_q, committed_d;
   logic [9:0]                  ptr_q, ptr_d;
   logic [2:0][15:0]            trig1_q, trig1_d, trig2_q, trig2_d;
   logic [15:0]                 actl_q, actl_d, auxc_q, auxc_d;
   logic [15:0]                 rdata_q, rdata_d;
   logic                        wr_en, rd_en;
   logic [2:0]                  band_sel;
   logic [1:0]                  rate_ptr;

   assign wr_en    = reg_wr_i && clk_en_i;
   assign rd_en    = reg_rd_i && clk_en_i;
   assign band_sel = ptr_q[2:0];
   assign rate_ptr = ptr_q[9:8];

   // ---------------------------------------------------------------
   // Evaluation state
   // ---------------------------------------------------------------
   sar_st_t                     st_q, st_d;
   logic [2:0][5:0]             hit1_q, hit1_d, hit2_q, hit2_d;
   logic [2:0][15:0]            wmag_q, wmag_d;
   logic [2:0][7:0]             wbin_q, wbin_d;
   logic [2:0][5:0][1:0][3:0]   pers_q, pers_d;
   sar_hdr_t                    hdr_q, hdr_d;
   logic                        hvld_q, hvld_d;
   logic                        any1, any2, pin_en;
   logic                        rec_close;

   assign rec_close = (st_q == SAR_ACCUM) && rec_end_i && clk_en_i;

   // Register writes and command effects
   always_comb begin
      stage_d     = stage_q;
      active_d    = active_q;
      committed_d = committed_q;
      ptr_d       = ptr_q;
      trig1_d     = trig1_q;
      trig2_d     = trig2_q;
      actl_d      = actl_q;
      auxc_d      = auxc_q;
      if (wr_en) begin
         case (reg_addr_i)
            OFS_GLOBAL_COMMAND: begin
               if (reg_wdata_i[CMD_CLEAR_BIT]) begin
                  stage_d     = '0;
                  active_d    = '0;
                  committed_d = 1'b0;
               // commit staged bands; refused once committed
               end else if (reg_wdata_i[CMD_SAVE_BIT] && !committed_q) begin
                  active_d    = stage_q;
                  committed_d = 1'b1;
               end
            end
            OFS_BAND_PTR:  ptr_d = {reg_wdata_i[9:8], 5'h00, reg_wdata_i[2:0]};
            // per band, per rate boundaries; band 0 and 7 are dropped
            OFS_BAND_LOW: begin
               if (band_sel >= 3'h1 && band_sel <= 3'h6) begin
                  stage_d[rate_ptr][band_sel - 3'h1][0] = reg_wdata_i[7:0];
               end
            end
            OFS_BAND_HIGH: begin
               if (band_sel >= 3'h1 && band_sel <= 3'h6) begin
                  stage_d[rate_ptr][band_sel - 3'h1][1] = reg_wdata_i[7:0];
               end
            end
            OFS_TRIG1:        trig1_d[0] = reg_wdata_i;
            OFS_TRIG1 + 7'h2: trig1_d[1] = reg_wdata_i;
            OFS_TRIG1 + 7'h4: trig1_d[2] = reg_wdata_i;
            OFS_TRIG2:        trig2_d[0] = reg_wdata_i;
            OFS_TRIG2 + 7'h2: trig2_d[1] = reg_wdata_i;
            OFS_TRIG2 + 7'h4: trig2_d[2] = reg_wdata_i;
            OFS_ALARM_CONTROL:     actl_d = {4'h0, reg_wdata_i[11:0]};
            OFS_AUX_CTRL:     auxc_d = reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Read mux, registered so data leaves from a flip-flop
   always_comb begin
      rdata_d = rdata_q;
      if (rd_en) begin
         case (reg_addr_i)
            OFS_BAND_PTR:     rdata_d = {6'h00, ptr_q};
            OFS_BAND_LOW:     rdata_d = {8'h00, stage_q[rate_ptr][band_sel - 3'h1][0]};
            OFS_BAND_HIGH:    rdata_d = {8'h00, stage_q[rate_ptr][band_sel - 3'h1][1]};
            OFS_TRIG1:        rdata_d = trig1_q[0];
            OFS_TRIG1 + 7'h2: rdata_d = trig1_q[1];
            OFS_TRIG1 + 7'h4: rdata_d = trig1_q[2];
            OFS_TRIG2:        rdata_d = trig2_q[0];
            OFS_TRIG2 + 7'h2: rdata_d = trig2_q[1];
            OFS_TRIG2 + 7'h4: rdata_d = trig2_q[2];
            OFS_ALARM_CONTROL:     rdata_d = actl_q;
            OFS_AUX_CTRL:     rdata_d = auxc_q;
            OFS_STAT:         rdata_d = hdr_q.ax[0].stat;
            OFS_STAT + 7'h2:  rdata_d = hdr_q.ax[1].stat;
            OFS_STAT + 7'h4:  rdata_d = hdr_q.ax[2].stat;
            OFS_PEAK:         rdata_d = hdr_q.ax[0].peak;
            OFS_PEAK + 7'h2:  rdata_d = hdr_q.ax[1].peak;
            OFS_PEAK + 7'h4:  rdata_d = hdr_q.ax[2].peak;
            OFS_BIN:          rdata_d = hdr_q.ax[0].bin;
            OFS_BIN + 7'h2:   rdata_d = hdr_q.ax[1].bin;
            OFS_BIN + 7'h4:   rdata_d = hdr_q.ax[2].bin;
            default:          rdata_d = 16'h0000;
         endcase
      end
   end

   // Record accumulation and status build
   always_comb begin
      logic [3:0] dly;
      logic [1:0] ax;
      logic [2:0] crit1, crit2;
      logic       f1, f2, exceed;
      dly    = actl_q[ACTL_DLY_LSB +: 4];
      ax     = bin_i.axis;
      crit1  = 3'h0;
      crit2  = 3'h0;
      f1     = 1'b0;
      f2     = 1'b0;
      exceed = 1'b0;
      st_d   = st_q;
      hit1_d = hit1_q;
      hit2_d = hit2_q;
      wmag_d = wmag_q;
      wbin_d = wbin_q;
      pers_d = pers_q;
      hdr_d  = hdr_q;
      hvld_d = 1'b0;
      case (st_q)
         SAR_IDLE: begin
            if (rec_start_i) begin
               st_d   = SAR_ACCUM;
               hit1_d = '0;
               hit2_d = '0;
               wmag_d = '0;
               wbin_d = '0;
            end
         end
         SAR_ACCUM: begin
            // bins of a disabled axis are ignored
            if (bin_valid_i && ax < 2'd3 && actl_q[ax]) begin
               for (int b = 0; b < NUM_BANDS; b++) begin
                  if (in_band(bin_i.idx, active_q[rate_sel_i][b])) begin
                     if (bin_i.mag > trig1_q[ax]) begin
                        hit1_d[ax][b] = 1'b1;
                        exceed        = 1'b1;
                     end
                     if (bin_i.mag > trig2_q[ax]) begin
                        hit2_d[ax][b] = 1'b1;
                        exceed        = 1'b1;
                     end
                  end
               end
               if (exceed && bin_i.mag > wmag_q[ax]) begin
                  wmag_d[ax] = bin_i.mag;
                  wbin_d[ax] = bin_i.idx;
               end
            end
            if (rec_end_i) begin
               st_d         = SAR_IDLE;
               hvld_d       = 1'b1;
               // header carries the generic diagnostic flags
               hdr_d.diag   = diag_flags_i;
               for (int a = 0; a < NUM_AXES; a++) begin
                  crit1 = 3'h0;
                  crit2 = 3'h0;
                  hdr_d.ax[a].stat = STAT_RST;
                  for (int b = NUM_BANDS - 1; b >= 0; b--) begin
                     // flag only once persistence reaches the delay
                     f1 = hit1_q[a][b] && (pers_q[a][b][0] >= dly);
                     f2 = hit2_q[a][b] && (pers_q[a][b][1] >= dly);
                     pers_d[a][b][0] = !hit1_q[a][b] ? 4'h0 :
                                       (pers_q[a][b][0] == 4'hF ? 4'hF : pers_q[a][b][0] + 4'h1);
                     pers_d[a][b][1] = !hit2_q[a][b] ? 4'h0 :
                                       (pers_q[a][b][1] == 4'hF ? 4'hF : pers_q[a][b][1] + 4'h1);
                     // level-1 at 2n+2, level-2 at 2n+3
                     hdr_d.ax[a].stat[2*b + 4] = f1;
                     hdr_d.ax[a].stat[2*b + 5] = f2;
                     if (f1) crit1 = 3'(b + 1);
                     if (f2) crit2 = 3'(b + 1);
                  end
                  // lowest band at the highest level is most critical
                  hdr_d.ax[a].stat[2:0] = (crit2 != 3'h0) ? crit2 : crit1;
                  // worst magnitude and bin enter the header
                  hdr_d.ax[a].peak = wmag_q[a];
                  hdr_d.ax[a].bin  = {8'h00, wbin_q[a]};
               end
            end
         end
         default: st_d = SAR_IDLE;
      endcase
   end

   // both the function select and the enable bit are needed
   assign pin_en = (auxc_q[AUXC_SEL_LSB +: 4] == AUX_SEL_ALARM) && actl_q[ACTL_PIN_BIT];
   always_comb begin
      any1 = 1'b0;
      any2 = 1'b0;
      for (int a = 0; a < NUM_AXES; a++) begin
         for (int b = 0; b < NUM_BANDS; b++) begin
            any1 = any1 | hdr_q.ax[a].stat[2*b + 4];
            any2 = any2 | hdr_q.ax[a].stat[2*b + 5];
         end
      end
   end

   // Registers; clock enable low freezes everything
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage_q     <= '0;
         active_q    <= '0;
         committed_q <= 1'b0;
         ptr_q       <= '0;
         trig1_q     <= '0;
         trig2_q     <= '0;
         actl_q      <= ACTL_RST;
         auxc_q      <= AUXC_RST;
         rdata_q     <= 16'h0000;
         st_q        <= SAR_IDLE;
         hit1_q      <= '0;
         hit2_q      <= '0;
         wmag_q      <= '0;
         wbin_q      <= '0;
         pers_q      <= '0;
         hdr_q       <= '0;
         hvld_q      <= 1'b0;
      end else if (clk_en_i) begin
         stage_q     <= stage_d;
         active_q    <= active_d;
         committed_q <= committed_d;
         ptr_q       <= ptr_d;
         trig1_q     <= trig1_d;
         trig2_q     <= trig2_d;
         actl_q      <= actl_d;
         auxc_q      <= auxc_d;
         rdata_q     <= rdata_d;
         st_q        <= st_d;
         hit1_q      <= hit1_d;
         hit2_q      <= hit2_d;
         wmag_q      <= wmag_d;
         wbin_q      <= wbin_d;
         pers_q      <= pers_d;
         hdr_q       <= hdr_d;
         hvld_q      <= hvld_d;
      end
   end

   // pin one warning, pin two critical; released when not enabled
   assign aux_pin_one_o      = pin_en && any1;
   assign aux_pin_two_o      = pin_en && any2;
   assign aux_pin_one_oe_b_o = !pin_en;
   assign aux_pin_two_oe_b_o = !pin_en;
   assign reg_rdata_o        = rdata_q;
   assign hdr_o              = hdr_q;
   assign hdr_valid_o        = hvld_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_clear_cmd;
      wr_en && reg_addr_i == OFS_GLOBAL_COMMAND && reg_wdata_i[CMD_CLEAR_BIT];
   endsequence
   sequence s_save_cmd;
      wr_en && reg_addr_i == OFS_GLOBAL_COMMAND && reg_wdata_i[CMD_SAVE_BIT]
         && !reg_wdata_i[CMD_CLEAR_BIT];
   endsequence

   a_clear_erases: assert property (s_clear_cmd |=> !committed_q && active_q == '0)
      else $error("clear did not erase band definitions");
   a_save_commits: assert property (s_save_cmd ##0 !committed_q |=> committed_q)
      else $error("save did not commit");
   a_save_refused: assert property (s_save_cmd ##0 committed_q |=> $stable(active_q))
      else $error("second save changed active bands");
   a_pin_gated: assert property (!actl_q[ACTL_PIN_BIT] |-> !aux_pin_one_o && !aux_pin_two_o)
      else $error("alarm pin active while disabled");
   a_pin_two_crit: assert property (pin_en && hdr_q.ax[0].stat[13] |-> aux_pin_two_o)
      else $error("critical flag not shown on pin two");
   a_hdr_pulse: assert property (rec_close |=> hvld_q ##1 (!hvld_q || !clk_en_i))
      else $error("header update not one pulse");
   a_stat_layout: assert property (hdr_q.ax[1].stat[3] == 1'b0
      && hdr_q.ax[1].stat[2:0] <= 3'h6)
      else $error("status low field out of range");
   a_crit_needs_flag: assert property (hdr_q.ax[2].stat[2:0] != 3'h0
      |-> hdr_q.ax[2].stat[15:4] != 12'h000)
      else $error("critical band without flag");
   a_axis_off: assert property (rec_close && !actl_q[2] |=> hdr_q.ax[2].stat[15:4] == 12'h000)
      else $error("disabled axis raised alarm");
   a_bin_upper: assert property (hdr_q.ax[0].bin[15:8] == 8'h00)
      else $error("bin register upper byte set");
endmodule

// File: bench/sar_rec_src.sv
// Purpose: Record source model feeding bins and record framing to the core.
// Assumes: Drives on the falling edge of clk_sys_i; one record at a time.
// Notes:   Gap cycles between bins model a slow FFT engine.
`timescale 1ns/100ps
module sar_rec_src (
   input  wire logic          clk_sys_i,
   output logic               rec_start_o,
   output logic               rec_end_o,
   output logic               bin_valid_o,
   output sar_pkg::sar_bin_t  bin_o
);
   import sar_pkg::*;

   // Idle values before the first record
   initial begin
      rec_start_o = 1'b0;
      rec_end_o   = 1'b0;
      bin_valid_o = 1'b0;
      bin_o       = '0;
   end

   // Start, bins, then end after gap idle cycles (one when gap is 0) past the last bin
   task automatic play(input sar_bin_t bl[$], input int gap);
      @(negedge clk_sys_i);
      rec_start_o = 1'b1;
      @(negedge clk_sys_i);
      rec_start_o = 1'b0;
      foreach (bl[i]) begin
         bin_o       = bl[i];
         bin_valid_o = 1'b1;
         @(negedge clk_sys_i);
         if (gap > 0) begin
            // Stale bus is inverted so a late sample cannot pass
            bin_valid_o = 1'b0;
            bin_o       = ~bl[i];
            repeat (gap) @(negedge clk_sys_i);
         end
      end
      if (gap == 0) begin
         bin_valid_o = 1'b0;
         bin_o       = ~bin_o;
         @(negedge clk_sys_i);
      end
      rec_end_o = 1'b1;
      @(negedge clk_sys_i);
      rec_end_o = 1'b0;
   endtask
endmodule

// File: bench/sar_core_tb_top.sv
// Purpose: Self-checking bench for the spectral alarm reporting core.
// Assumes: Register port and record source both driven on falling edges.
// Notes:   Expected words are built by hand from band and trigger setup.
`timescale 1ns/100ps
module sar_core_tb_top;
   import sar_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        clk_en_i  = 1'b1;
   logic        reg_wr_i  = 1'b0;
   logic        reg_rd_i  = 1'b0;
   logic [6:0]  reg_addr_i = 7'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic [15:0] reg_rdata_o;
   logic [1:0]  rate_sel_i = 2'h0;
   logic [5:0]  diag_flags_i = 6'h2A;
   logic        rec_start_i, rec_end_i, bin_valid_i, hdr_valid_o;
   sar_bin_t    bin_i;
   sar_hdr_t    hdr_o;
   logic        aux_pin_one_o, aux_pin_one_oe_b_o, aux_pin_two_o, aux_pin_two_oe_b_o;
   int          mismatches = 0;
   int          check_count = 0;
   int          cyc = 0;
   sar_bin_t    bq[$];

   sar_core dut_u (.clk_sys_i, .rst_b_i, .clk_en_i, .reg_wr_i, .reg_rd_i,
      .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .rate_sel_i, .diag_flags_i,
      .rec_start_i, .rec_end_i, .bin_valid_i, .bin_i, .hdr_o, .hdr_valid_o,
      .aux_pin_one_o, .aux_pin_one_oe_b_o, .aux_pin_two_o, .aux_pin_two_oe_b_o);

   sar_rec_src src_u (.clk_sys_i, .rec_start_o(rec_start_i), .rec_end_o(rec_end_i),
      .bin_valid_o(bin_valid_i), .bin_o(bin_i));

   // 125 MHz system clock
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Hang guard, far beyond the few hundred cycles needed
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   // --------------------------------------------------------------
   // Checks and verdict
   // --------------------------------------------------------------
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: word %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: flag %b expected %b", $time, g, e);
      end
   endtask

   task automatic stop_test();
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // --------------------------------------------------------------
   // Register port access
   // --------------------------------------------------------------
   task automatic wr16(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk_sys_i);
      reg_wr_i    = 1'b1;
      reg_addr_i  = a;
      reg_wdata_i = d;
      @(negedge clk_sys_i);
      reg_wr_i = 1'b0;
   endtask

   // Read data is registered, so sample a full cycle after the strobe
   task automatic rchk(input logic [6:0] a, input logic [15:0] e);
      @(negedge clk_sys_i);
      reg_rd_i   = 1'b1;
      reg_addr_i = a;
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
      @(negedge clk_sys_i);
      chk16(reg_rdata_o, e);
   endtask

   task automatic band(input logic [1:0] r, input logic [2:0] n, input logic [7:0] lo,
                       input logic [7:0] hi);
      wr16(OFS_BAND_PTR, {6'h00, r, 5'h00, n});
      wr16(OFS_BAND_LOW, {8'h00, lo});
      wr16(OFS_BAND_HIGH, {8'h00, hi});
   endtask

   // Register view and header view of one axis must agree
   task automatic axis_chk(input int a, input logic [15:0] s, input logic [15:0] p,
                           input logic [15:0] b);
      rchk(OFS_STAT + 7'(2 * a), s);
      rchk(OFS_PEAK + 7'(2 * a), p);
      rchk(OFS_BIN + 7'(2 * a), b);
      chk16(hdr_o.ax[a].stat, s);
      chk16(hdr_o.ax[a].peak, p);
      chk16(hdr_o.ax[a].bin, b);
   endtask

   // One record through the source, then the header strobe
   task automatic rec(input int gap);
      src_u.play(bq, gap);
      chk1(hdr_valid_o, 1'b1);
      chk16({10'h000, hdr_o.diag}, {10'h000, diag_flags_i});
      @(negedge clk_sys_i);
      chk1(hdr_valid_o, 1'b0);
      bq.delete();
   endtask

   task automatic pins(input logic one, input logic two, input logic oe_b);
      chk1(aux_pin_one_oe_b_o, oe_b);
      chk1(aux_pin_two_oe_b_o, oe_b);
      if (oe_b == 1'b0) begin
         chk1(aux_pin_one_o, one);
         chk1(aux_pin_two_o, two);
      end
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (5) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      pins(1'b0, 1'b0, 1'b1);
      for (int a = 0; a < 3; a++) axis_chk(a, 16'h0000, 16'h0000, 16'h0000);
      rchk(OFS_ALARM_CONTROL, ACTL_RST);
      rchk(OFS_AUX_CTRL, AUXC_RST);
      rchk(OFS_GLOBAL_COMMAND, 16'h0000);
      rchk(7'h7E, 16'h0000);
      // Bands 2 and 5 at rate 0, x and y enabled, z left off
      wr16(OFS_GLOBAL_COMMAND, 16'h0200);
      band(2'h0, 3'h2, 8'h0A, 8'h14);
      band(2'h0, 3'h5, 8'h64, 8'h78);
      wr16(OFS_GLOBAL_COMMAND, 16'h1000);
      wr16(OFS_TRIG1, 16'h0064);
      wr16(OFS_TRIG2, 16'h00C8);
      wr16(OFS_TRIG1 + 7'h02, 16'h0032);
      wr16(OFS_TRIG2 + 7'h02, 16'h003C);
      wr16(OFS_AUX_CTRL, 16'h0010);
      wr16(OFS_ALARM_CONTROL, 16'h0043);
      // Level-1 in band 2 and level-2 in band 5 on x; z and axis 3 ignored
      bq = '{'{2'd0, 8'd15, 16'd150}, '{2'd0, 8'd110, 16'd250}, '{2'd1, 8'd15, 16'd40},
             '{2'd2, 8'd15, 16'd999}, '{2'd3, 8'd15, 16'd999}};
      rec(0);
      axis_chk(0, 16'h3045, 16'd250, 16'd110);
      axis_chk(1, 16'h0000, 16'h0000, 16'h0000);
      axis_chk(2, 16'h0000, 16'h0000, 16'h0000);
      pins(1'b1, 1'b1, 1'b0);
      wr16(OFS_AUX_CTRL, 16'h0000);
      pins(1'b0, 1'b0, 1'b1);
      wr16(OFS_AUX_CTRL, 16'h0010);
      // Slow source, level-1 only on y
      diag_flags_i = 6'h15;
      bq = '{'{2'd1, 8'd12, 16'd55}};
      rec(2);
      axis_chk(1, 16'h0042, 16'd55, 16'd12);
      axis_chk(0, 16'h0000, 16'h0000, 16'h0000);
      pins(1'b1, 1'b0, 1'b0);
      // Rate 1 has no bands defined
      rate_sel_i = 2'h1;
      bq = '{'{2'd0, 8'd15, 16'd150}};
      rec(0);
      axis_chk(0, 16'h0000, 16'h0000, 16'h0000);
      rate_sel_i = 2'h0;
      // Second save without a clear is ignored
      band(2'h0, 3'h2, 8'h00, 8'h05);
      wr16(OFS_GLOBAL_COMMAND, 16'h1000);
      bq = '{'{2'd0, 8'd3, 16'd150}};
      rec(0);
      axis_chk(0, 16'h0000, 16'h0000, 16'h0000);
      // Clear, reprogram and save takes effect
      wr16(OFS_GLOBAL_COMMAND, 16'h0200);
      band(2'h0, 3'h2, 8'h00, 8'h05);
      wr16(OFS_GLOBAL_COMMAND, 16'h1000);
      bq = '{'{2'd0, 8'd3, 16'd150}};
      rec(0);
      axis_chk(0, 16'h0042, 16'd150, 16'd3);
      // Clock enable low: neither write may land, bands must survive
      clk_en_i = 1'b0;
      wr16(OFS_TRIG1, 16'hFFFF);
      wr16(OFS_GLOBAL_COMMAND, 16'h0200);
      clk_en_i = 1'b1;
      rchk(OFS_TRIG1, 16'h0064);
      // Delay of two records; a miss first resets the run of hits
      wr16(OFS_ALARM_CONTROL, 16'h0243);
      bq = '{'{2'd0, 8'd15, 16'd150}};
      rec(0);
      for (int k = 0; k < 3; k++) begin
         bq = '{'{2'd0, 8'd3, 16'd150}};
         rec(0);
         axis_chk(0, (k == 2) ? 16'h0042 : 16'h0000, 16'd150, 16'd3);
      end
      stop_test();
   end
endmodule
